// ---- imw_mask_watchdog.sv ----
// Interrupt mask bank, event monitor and millisecond watchdog behind an Avalon-MM slave.
`timescale 1ns/100ps
// What this block does
// - One mask bit per monitor bit, eight bytes
// - Monitor bit sets only when mask is one
// - All mask bits reset to zero
// - Clock byte: bits 5..2 lock transitions
// - Clock byte: bit1 cal done, bit0 started
// - Second byte: ROM load, sync, watchdog
// - Second byte: memory fault, memory complete
// - Loop byte: switch, closed, free, holdover
// - Loop byte: frequency and phase lock changes
// - Limiter byte: history, unclamp, clamp bits
// - Limiter byte: slew enter and leave enables
// - Reference byte: A validated, cleared, faulted
// - Reference byte: B bits; next byte reserved
// - Watchdog period 16-bit milliseconds, low first
// - Period resets zero; zero disables watchdog
// - Pin shows events only when role bit 2 is zero
module imw_mask_watchdog
	import imw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register bus
	input wire logic [IMW_BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Internal event pulses, one per monitor bit
	input wire logic [IMW_MON_BYTES*8-1:0] event_in,
	// Internal status shown on the pin when its role bit is one
	input wire logic status_sel_in,
	// Interrupt outputs
	output logic irq,
	output logic irq_pin_out
);

	// ==========================================================================
	// Helpers
	function automatic logic [7:0] imw_wmask(input logic [2:0] idx);
		case (idx)
			3'h0: imw_wmask = IMW_WMASK_CLOCK_PLL;
			3'h1: imw_wmask = IMW_WMASK_SYNC_WD_NVM;
			3'h2: imw_wmask = IMW_WMASK_LOOP_STATE;
			3'h3: imw_wmask = IMW_WMASK_LIMITER;
			3'h4: imw_wmask = IMW_WMASK_REFERENCE;
			default: imw_wmask = IMW_WMASK_RESERVED;
		endcase
	endfunction

	function automatic logic in_range(input logic [11:0] idx, input logic [11:0] lo, input logic [11:0] hi);
		in_range = (idx >= lo) && (idx <= hi);
	endfunction

	// ==========================================================================
	// State
	imw_state_t s_reg;
	imw_state_t s_next;
	logic [11:0] idx;
	logic [2:0] mask_sel;
	logic [2:0] mon_sel;
	logic wd_expire;
	logic [IMW_MON_BYTES-1:0][7:0] events;
	logic [IMW_MON_BYTES-1:0][7:0] wmasks;

	assign idx = avs_address[IMW_BUS_AW-1:2];
	assign mask_sel = 3'(idx - IMW_IDX_CLOCK_PLL);
	assign mon_sel = 3'(idx - IMW_IDX_MONITOR_LO);

	// Slew enables sit in the two low limiter bits; the monitor follows the same layout.
	genvar g;
	generate
		for (g = 0; g < IMW_MON_BYTES; g++) begin : g_wm
			assign wmasks[g] = imw_wmask(3'(g));
		end
	endgenerate

	// ==========================================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		wd_expire = 1'b0;
		events = event_in;

		// Watchdog: tick counts one millisecond, then the remaining count steps down.
		if (s_reg.wd_period != IMW_RST_WD_PERIOD) begin
			if (s_reg.wd_tick == IMW_MS_CW'(IMW_MS_CYCLES - 1)) begin
				s_next.wd_tick = '0;
				if (s_reg.wd_ms_left == 16'h0001) begin
					wd_expire = 1'b1;
					s_next.wd_ms_left = s_reg.wd_period;
				end else begin
					s_next.wd_ms_left = s_reg.wd_ms_left - 16'h0001;
				end
			end else begin
				s_next.wd_tick = s_reg.wd_tick + 1'b1;
			end
		end
		events[IMW_BYTE_SYNC_WD_NVM][IMW_BIT_WD_EXPIRY] = event_in[IMW_BYTE_SYNC_WD_NVM*8+IMW_BIT_WD_EXPIRY] | wd_expire;

		// Bus: one wait cycle, then the answer.
		s_next.bus_state = IMW_BUS_IDLE;
		unique case (s_reg.bus_state)
			IMW_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					s_next.bus_state = IMW_BUS_ANSWER;
				end
			end
			IMW_BUS_ANSWER: begin
				s_next.bus_state = IMW_BUS_IDLE;
			end
			default: begin
				s_next.bus_state = IMW_BUS_IDLE;
			end
		endcase

		// Events land only where enabled; disabled events are simply dropped.
		s_next.monitor = s_reg.monitor | (events & s_reg.mask);

		if (s_reg.bus_state == IMW_BUS_IDLE && avs_write) begin
			if (in_range(idx, IMW_IDX_CLOCK_PLL, IMW_IDX_RESERVED)) begin
				s_next.mask[mask_sel] = avs_writedata[7:0] & wmasks[mask_sel];
			end
			if (in_range(idx, IMW_IDX_MONITOR_LO, IMW_IDX_MONITOR_HI)) begin
				// Write one to clear; a same-cycle event still sets.
				s_next.monitor[mon_sel] = (s_reg.monitor[mon_sel] & ~avs_writedata[7:0])
					| (events[mon_sel] & s_reg.mask[mon_sel]);
			end
			if (idx == IMW_IDX_WD_LOW) begin
				s_next.wd_period[7:0] = avs_writedata[7:0];
			end
			if (idx == IMW_IDX_WD_HIGH) begin
				s_next.wd_period[15:8] = avs_writedata[7:0];
			end
			if (idx == IMW_IDX_WD_LOW || idx == IMW_IDX_WD_HIGH) begin
				s_next.wd_tick = '0;
				s_next.wd_ms_left = (idx == IMW_IDX_WD_LOW) ? {s_reg.wd_period[15:8], avs_writedata[7:0]}
					: {avs_writedata[7:0], s_reg.wd_period[7:0]};
			end
			if (in_range(idx, IMW_IDX_MONITOR_LO + 12'h008, IMW_IDX_MONITOR_LO + 12'h00f)) begin
				s_next.irq_mask[3'(idx - IMW_IDX_MONITOR_LO - 12'h008)] = avs_writedata[7:0];
			end
			if (idx == IMW_IDX_PIN_ROLE) begin
				s_next.pin_role = avs_writedata[7:0];
			end
		end

		if (s_reg.bus_state == IMW_BUS_IDLE && avs_read) begin
			s_next.readdata = '0;
			if (in_range(idx, IMW_IDX_CLOCK_PLL, IMW_IDX_RESERVED)) begin
				s_next.readdata[7:0] = s_reg.mask[mask_sel];
			end else if (in_range(idx, IMW_IDX_MONITOR_LO, IMW_IDX_MONITOR_HI)) begin
				s_next.readdata[7:0] = s_reg.monitor[mon_sel];
			end else if (in_range(idx, IMW_IDX_MONITOR_LO + 12'h008, IMW_IDX_MONITOR_LO + 12'h00f)) begin
				s_next.readdata[7:0] = s_reg.irq_mask[3'(idx - IMW_IDX_MONITOR_LO - 12'h008)];
			end else if (idx == IMW_IDX_WD_LOW) begin
				s_next.readdata[7:0] = s_reg.wd_period[7:0];
			end else if (idx == IMW_IDX_WD_HIGH) begin
				s_next.readdata[7:0] = s_reg.wd_period[15:8];
			end else if (idx == IMW_IDX_WD_STATUS) begin
				s_next.readdata[15:0] = s_reg.wd_ms_left;
			end else if (idx == IMW_IDX_PIN_ROLE) begin
				s_next.readdata[7:0] = s_reg.pin_role;
			end
		end

		// The pin is registered so it cannot glitch while monitor bits change.
		s_next.irq_pin = s_reg.pin_role[IMW_BIT_PIN_ROLE] ? status_sel_in
			: (|(s_next.monitor & s_next.irq_mask));
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.mask <= {IMW_MON_BYTES{IMW_RST_MASK}};
			s_reg.wd_period <= IMW_RST_WD_PERIOD;
			s_reg.pin_role <= IMW_RST_PIN_ROLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================================
	// Outputs
	logic irq_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(s_next.monitor & s_next.irq_mask);
		end
	end

	assign irq = irq_reg;
	assign irq_pin_out = s_reg.irq_pin;
	assign avs_readdata = s_reg.readdata;
	assign avs_waitrequest = !(s_reg.bus_state == IMW_BUS_ANSWER);

endmodule

// ---- imw_pkg.sv ----
// Package for the interrupt mask bank and watchdog: offsets, layouts, reset values, timing.
package imw_pkg;

	// ==========================================================================
	// Register indices (printed offsets; byte address is four times the index)
	localparam logic [11:0] IMW_IDX_CLOCK_PLL = 12'h20a;
	localparam logic [11:0] IMW_IDX_SYNC_WD_NVM = 12'h20b;
	localparam logic [11:0] IMW_IDX_LOOP_STATE = 12'h20c;
	localparam logic [11:0] IMW_IDX_LIMITER = 12'h20d;
	localparam logic [11:0] IMW_IDX_REFERENCE = 12'h20e;
	localparam logic [11:0] IMW_IDX_RESERVED = 12'h20f;
	localparam logic [11:0] IMW_IDX_WD_LOW = 12'h210;
	localparam logic [11:0] IMW_IDX_WD_HIGH = 12'h211;
	localparam logic [11:0] IMW_IDX_PIN_ROLE = 12'h209;
	localparam logic [11:0] IMW_IDX_MONITOR_LO = 12'hd02;
	localparam logic [11:0] IMW_IDX_MONITOR_HI = 12'hd09;
	localparam logic [11:0] IMW_IDX_WD_STATUS = 12'h212;
	localparam int IMW_MON_BYTES = 8;
	localparam int IMW_BUS_AW = 14;

	// ==========================================================================
	// Writable bit masks per byte; reserved bits read zero
	localparam logic [7:0] IMW_WMASK_CLOCK_PLL = 8'h3f;
	localparam logic [7:0] IMW_WMASK_SYNC_WD_NVM = 8'h1f;
	localparam logic [7:0] IMW_WMASK_LOOP_STATE = 8'hff;
	localparam logic [7:0] IMW_WMASK_LIMITER = 8'h1f;
	localparam logic [7:0] IMW_WMASK_REFERENCE = 8'h77;
	localparam logic [7:0] IMW_WMASK_RESERVED = 8'h00;

	// ==========================================================================
	// Field positions
	localparam int IMW_BIT_WD_EXPIRY = 2;
	localparam int IMW_BYTE_SYNC_WD_NVM = 1;
	localparam int IMW_BIT_PIN_ROLE = 2;
	localparam int IMW_BIT_LIMIT_SLEW_ON = 0;
	localparam int IMW_BIT_LIMIT_SLEW_OFF = 1;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] IMW_RST_MASK = 8'h00;
	localparam logic [15:0] IMW_RST_WD_PERIOD = 16'h0000;
	localparam logic [7:0] IMW_RST_PIN_ROLE = 8'h04;

	// ==========================================================================
	// Timing
	localparam int IMW_CLK_HZ = 200000000;
	localparam int IMW_MS_PER_S = 1000;
	localparam int IMW_MS_CYCLES = IMW_CLK_HZ / IMW_MS_PER_S;
	localparam int IMW_MS_CW = 18;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic [IMW_BUS_AW-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} imw_bus_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} imw_bus_rsp_t;

	typedef enum logic [1:0] {
		IMW_BUS_IDLE = 2'b00,
		IMW_BUS_ANSWER = 2'b01
	} imw_bus_state_t;

	typedef struct packed {
		imw_bus_state_t bus_state;
		logic [31:0] readdata;
		logic [IMW_MON_BYTES-1:0][7:0] mask;
		logic [IMW_MON_BYTES-1:0][7:0] monitor;
		logic [IMW_MON_BYTES-1:0][7:0] irq_mask;
		logic [7:0] pin_role;
		logic [15:0] wd_period;
		logic [15:0] wd_ms_left;
		logic [IMW_MS_CW-1:0] wd_tick;
		logic irq_pin;
	} imw_state_t;

endpackage

// ---- imw_mask_watchdog_props.sv ----
// Checker for the bus handshake, reserved reads and interrupt outputs.
`timescale 1ns/100ps
module imw_mask_watchdog_props
	import imw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register bus
	input wire logic [IMW_BUS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Events and interrupt outputs
	input wire logic [IMW_MON_BYTES*8-1:0] event_in,
	input wire logic status_sel_in,
	input wire logic irq,
	input wire logic irq_pin_out
);
	// ==========================================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	answer_in_time_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("request not answered in time");
	single_answer_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer cycle longer than one");
	answer_needs_req_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
	// Reset must win even while it is held, so this one is never disabled.
	reset_quiet_a: assert property (disable iff (1'b0) srst |=> avs_waitrequest && !irq)
		else $error("outputs not quiet after reset");
	reserved_read_a: assert property (avs_read && !avs_waitrequest && avs_address[13:2] == IMW_IDX_RESERVED
		|-> avs_readdata == 32'h0) else $error("reserved byte read nonzero");
	irq_cause_a: assert property ($rose(irq) |-> $past(|event_in) || $past(avs_write))
		else $error("interrupt raised without cause");
	irq_clear_a: assert property ($fell(irq) |-> $past(avs_write, 2) || $past(avs_write) || $past(srst))
		else $error("interrupt dropped without a write");
	pin_source_a: assert property (irq_pin_out == irq || irq_pin_out == $past(status_sel_in))
		else $error("pin shows neither source");
	readdata_hold_a: assert property (!$past(avs_read) && !$past(srst) |-> $stable(avs_readdata))
		else $error("read data changed without read");
endmodule
bind imw_mask_watchdog imw_mask_watchdog_props i_props (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .event_in, .status_sel_in, .irq, .irq_pin_out);

// ---- imw_mask_watchdog_tb.sv ----
// Testbench for the interrupt mask bank and watchdog.
`timescale 1ns/100ps
module imw_mask_watchdog_tb;
	import imw_pkg::*;
	// ==========================================================================
	// Signals
	logic ref_clk = 0, srst = 1, rd = 0, wr = 0, sel = 0, wreq, irq, pin;
	logic [IMW_BUS_AW-1:0] adr = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic [63:0] ev = '0;
	logic [7:0] wm [6] = '{IMW_WMASK_CLOCK_PLL, IMW_WMASK_SYNC_WD_NVM, IMW_WMASK_LOOP_STATE, IMW_WMASK_LIMITER,
		IMW_WMASK_REFERENCE, IMW_WMASK_RESERVED};
	int bad_count = 0, checked = 0, cyc = 0;
	imw_mask_watchdog i_dut (.ref_clk(ref_clk), .srst(srst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .event_in(ev), .status_sel_in(sel),
		.irq(irq), .irq_pin_out(pin));
	initial forever #2.5 ref_clk = ~ref_clk;
	// ==========================================================================
	// Tasks
	task conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// The request is held until waitrequest is seen low, then one idle edge separates accesses.
	task acc(input logic w, input logic [11:0] i, input logic [7:0] d);
		int n;
		n = 0;
		adr <= {i, 2'b00};
		rd <= !w;
		wr <= w;
		wdat <= {24'h0, d};
		@(posedge ref_clk);
		while (wreq !== 1'b0 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 20)
			bad_count++;
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rdc(input string n, input logic [11:0] i, input logic [7:0] e);
		acc(1'b0, i, 8'h00);
		chk(n, {24'h0, e}, q);
	endtask
	task pulse;
		ev <= '1;
		@(posedge ref_clk);
		ev <= '0;
		repeat (2) @(posedge ref_clk);
	endtask
	// ==========================================================================
	// Timeout and main sequence
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		for (int k = 0; k < 8; k++)
			rdc("reset value", 12'h20a + 12'(k), 8'h00);
		$display("test reset values done");
		pulse();
		for (int k = 0; k < 8; k++)
			rdc("monitor while masked", IMW_IDX_MONITOR_LO + 12'(k), 8'h00);
		for (int k = 0; k < 6; k++) begin
			acc(1'b1, 12'h20a + 12'(k), 8'hff);
			rdc("mask bits", 12'h20a + 12'(k), wm[k]);
		end
		for (int k = 0; k < 8; k++)
			rdc("monitor not pending", IMW_IDX_MONITOR_LO + 12'(k), 8'h00);
		pulse();
		for (int k = 0; k < 8; k++)
			rdc("monitor enabled", IMW_IDX_MONITOR_LO + 12'(k), (k < 6) ? wm[k] : 8'h00);
		$display("test masks and events done");
		sel <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("irq unmasked off", 32'h0, {31'h0, irq});
		chk("pin shows status", 32'h1, {31'h0, pin});
		acc(1'b1, 12'hd0a, 8'h01);
		acc(1'b1, IMW_IDX_PIN_ROLE, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		chk("pin shows irq", 32'h1, {31'h0, pin});
		acc(1'b1, IMW_IDX_MONITOR_LO, 8'hff);
		repeat (2) @(posedge ref_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		chk("pin follows irq", 32'h0, {31'h0, pin});
		$display("test interrupt done");
		acc(1'b1, IMW_IDX_WD_LOW, 8'ha5);
		acc(1'b1, IMW_IDX_WD_HIGH, 8'h3c);
		rdc("period low", IMW_IDX_WD_LOW, 8'ha5);
		rdc("period high", IMW_IDX_WD_HIGH, 8'h3c);
		rdc("unmapped", 12'h100, 8'h00);
		acc(1'b0, IMW_IDX_WD_STATUS, 8'h00);
		chk("watchdog count loaded", 32'h00003ca5, q);
		acc(1'b1, IMW_IDX_WD_LOW, 8'h07);
		acc(1'b0, IMW_IDX_WD_STATUS, 8'h00);
		chk("watchdog count restarted", 32'h00003c07, q);
		$display("test watchdog period done");
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rdc("mask after reset", IMW_IDX_LOOP_STATE, 8'h00);
		rdc("period after reset", IMW_IDX_WD_HIGH, 8'h00);
		rdc("monitor after reset", IMW_IDX_MONITOR_LO + 12'h002, 8'h00);
		$display("test second reset done");
		conclude();
	end
endmodule
